// ### design/psc_startup.sv
`timescale 1ns/10ps
`default_nettype none
`include "psc_consts.svh"

// What this block does
// R1: respond to one of five select strobes; strobe two when nothing chosen
// R2: keep configuration in serial flash and apply it at startup
// R3: page size of each dual port region is 1 MB or 512 kB, default 1 MB
// R4: four application modes; measurement and calibration only when measurement initialized
// R5: initialized modes refill emulation RAM from backup flash after power failure
// R6: uninitialized modes skip restore after power failure
// R7: power-on state setting decides enabled or inactive at ECU power on
// R8: switch debug clock to configured 20 or 40 MHz at startup condition
// R9: timeout zero switches clock and enables trigger right after reset
// R10: timeout n waits n ms; an earlier trigger ends the wait
// R11: timeout minus one waits for first trigger without limit
// R12: with no timeout configured, use 100 ms
// R13: static arbitration leaves the debug port alone; dynamic shares it
// R14: starting page is last active, working or reference as configured
// R15: ms counter of 16 bits restarts on each reset or power on
module psc_startup (
   // clock and reset
   input wire logic mclk,
   input wire logic resetn,
   // register port
   input wire logic [7:0] reg_addr,
   input wire logic [15:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [15:0] reg_rdata,
   // serial flash image stream (one word per pulse)
   input wire logic load_valid,
   input wire logic [15:0] load_word,
   // control unit pins
   input wire logic ecu_reset_n_pin,
   input wire logic ecu_power_pin,
   input wire logic ecu_trigger_pin,
   input wire logic power_fail,
   input wire logic [4:0] select_strobes_n,
   input wire logic last_page_working,
   // outputs to the probe core
   output logic selected,
   output logic page_512k,
   output logic meas_cal_allowed,
   output logic restore_request,
   output logic probe_enabled,
   output logic debug_clk_fast,
   output logic debug_clk_20mhz,
   output logic timer_trigger_en,
   output logic debugger_reserved,
   output logic start_working_page,
   output logic config_applied
);

   psc_pkg::psc_cfg_s cfg_ff;
   psc_pkg::psc_cfg_s nxt_cfg;
   logic [15:0] timeout_ff;
   logic [15:0] nxt_timeout;
   logic img_idx_ff;
   logic nxt_img_idx;
   logic applied_ff;
   logic nxt_applied;
   logic [15:0] rdata_ff;
   logic [15:0] nxt_rdata;

   typedef enum logic [1:0] {
      PSC_ST_IDLE,
      PSC_ST_WAIT,
      PSC_ST_RUN
   } psc_state_e;

   psc_state_e state_ff;
   psc_state_e nxt_state;
   logic clk_fast_ff;
   logic nxt_clk_fast;
   logic restore_ff;
   logic nxt_restore;
   logic enabled_ff;
   logic nxt_enabled;
   logic start_work_ff;
   logic nxt_start_work;
   logic sel_ff;
   logic nxt_sel;

   logic [8:0] pins_sync;
   logic ecu_rst_n;
   logic ecu_pwr;
   logic trig;
   logic pfail;
   logic [4:0] strobes_n;
   logic rst_prev_ff;
   logic pwr_prev_ff;
   logic ecu_start;
   logic ms_restart;
   logic [15:0] ms_count;
   logic init_mode;

   // ==========================================================
   // pin synchronisers
   psc_pin_sync #(
      .WIDTH(9)
   ) u_sync (
      .mclk(mclk),
      .resetn(resetn),
      .pin_in({select_strobes_n, power_fail, ecu_trigger_pin, ecu_power_pin,
               ecu_reset_n_pin}),
      .level_out(pins_sync)
   );

   assign ecu_rst_n = pins_sync[0];
   assign ecu_pwr = pins_sync[1];
   assign trig = pins_sync[2];
   assign pfail = pins_sync[3];
   assign strobes_n = pins_sync[8:4];

   // leaving reset while powered, or powering on out of reset
   assign ecu_start = (ecu_rst_n && !rst_prev_ff && ecu_pwr) ||
                      (ecu_pwr && !pwr_prev_ff && ecu_rst_n);
   assign ms_restart = ecu_start || !ecu_rst_n || !ecu_pwr;

   psc_ms_timer u_timer (
      .mclk(mclk),
      .resetn(resetn),
      .restart(ms_restart), // R15
      .run(state_ff == PSC_ST_WAIT),
      .ms_count(ms_count)
   );

   // ==========================================================
   // configuration registers and flash image load
   always_comb begin
      nxt_cfg = cfg_ff;
      nxt_timeout = timeout_ff;
      nxt_img_idx = img_idx_ff;
      nxt_applied = applied_ff;
      nxt_rdata = '0;
      if (load_valid) begin
         // image word 0 is the config word, word 1 the timeout
         if (!img_idx_ff) begin
            nxt_cfg = psc_pkg::psc_cfg_s'(load_word[10:0]); // R2
         end else begin
            nxt_timeout = load_word; // R2
            nxt_applied = 1'b1;
         end
         nxt_img_idx = !img_idx_ff;
      end else if (reg_wr) begin
         unique case (reg_addr)
            `PSC_REG_CONFIG_A: nxt_cfg = psc_pkg::psc_cfg_s'(reg_wdata[10:0]);
            `PSC_REG_TIMEOUT: nxt_timeout = reg_wdata;
            `PSC_REG_CONTROL: begin
               // rewind the image pointer for a fresh flash load
               if (reg_wdata[0]) begin
                  nxt_img_idx = 1'b0;
                  nxt_applied = 1'b0;
               end
            end
            default: ;
         endcase
      end
      if (reg_rd) begin
         unique case (reg_addr)
            `PSC_REG_CONFIG_A: nxt_rdata = {5'h00, cfg_ff};
            `PSC_REG_TIMEOUT: nxt_rdata = timeout_ff;
            `PSC_REG_CONTROL: nxt_rdata = {15'h0000, img_idx_ff};
            `PSC_REG_STATUS: nxt_rdata = {9'h000, sel_ff, start_work_ff,
                                          enabled_ff, restore_ff, clk_fast_ff,
                                          state_ff};
            `PSC_REG_LOAD_DATA: nxt_rdata = {15'h0000, applied_ff};
            default: nxt_rdata = '0;
         endcase
      end
   end

   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         cfg_ff <= psc_pkg::psc_cfg_s'(`PSC_CFG_RESET); // R1 R3 R4 R7 R8 R13 R14
         timeout_ff <= `PSC_TIMEOUT_RESET; // R12
         img_idx_ff <= 1'b0;
         applied_ff <= 1'b0;
         rdata_ff <= '0;
      end else begin
         cfg_ff <= nxt_cfg;
         timeout_ff <= nxt_timeout;
         img_idx_ff <= nxt_img_idx;
         applied_ff <= nxt_applied;
         rdata_ff <= nxt_rdata;
      end
   end

   assign reg_rdata = rdata_ff;

   // ==========================================================
   // startup sequencing
   assign init_mode = (cfg_ff.app_mode == psc_pkg::PSC_MODE_MEAS_INIT) ||
                      (cfg_ff.app_mode == psc_pkg::PSC_MODE_RAMX_INIT);

   always_comb begin
      nxt_state = state_ff;
      nxt_clk_fast = clk_fast_ff;
      nxt_restore = restore_ff;
      nxt_enabled = enabled_ff;
      nxt_start_work = start_work_ff;
      if (pfail) begin
         nxt_restore = init_mode; // R5 R6
      end else if (applied_ff && restore_ff) begin
         // restore is consumed once the flash image is back in place
         nxt_restore = 1'b0;
      end
      if (!ecu_rst_n || !ecu_pwr) begin
         nxt_state = PSC_ST_IDLE;
         nxt_clk_fast = 1'b0;
         if (!ecu_pwr) begin
            nxt_enabled = 1'b0;
         end
      end else begin
         unique case (state_ff)
            PSC_ST_IDLE: begin
               if (ecu_start) begin
                  nxt_enabled = !cfg_ff.power_on_inactive; // R7
                  unique case (cfg_ff.start_page)
                     psc_pkg::PSC_START_WORKING: nxt_start_work = 1'b1; // R14
                     psc_pkg::PSC_START_REFERENCE: nxt_start_work = 1'b0; // R14
                     default: nxt_start_work = last_page_working; // R14
                  endcase
                  if (timeout_ff == 16'h0000) begin
                     nxt_state = PSC_ST_RUN; // R9
                     nxt_clk_fast = 1'b1;
                  end else begin
                     nxt_state = PSC_ST_WAIT;
                  end
               end
            end
            PSC_ST_WAIT: begin
               // all-ones timeout never matches the count, waiting for trigger only
               if (trig) begin
                  nxt_state = PSC_ST_RUN; // R10 R11
                  nxt_clk_fast = 1'b1;
               end else if (timeout_ff != `PSC_TIMEOUT_INF &&
                            ms_count >= timeout_ff) begin
                  nxt_state = PSC_ST_RUN; // R10
                  nxt_clk_fast = 1'b1;
               end
            end
            PSC_ST_RUN: ;
            default: nxt_state = PSC_ST_IDLE;
         endcase
      end
   end

   // ==========================================================
   // chip select decode
   always_comb begin
      unique case (cfg_ff.select)
         psc_pkg::PSC_SEL_ONE: nxt_sel = !strobes_n[1]; // R1
         psc_pkg::PSC_SEL_THREE: nxt_sel = !strobes_n[3]; // R1
         psc_pkg::PSC_SEL_COMB: nxt_sel = !strobes_n[4]; // R1
         psc_pkg::PSC_SEL_ZERO: nxt_sel = !strobes_n[0]; // R1
         default: nxt_sel = !strobes_n[2]; // R1
      endcase
   end

   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         state_ff <= PSC_ST_IDLE;
         clk_fast_ff <= 1'b0;
         restore_ff <= 1'b0;
         enabled_ff <= 1'b0;
         start_work_ff <= 1'b0;
         sel_ff <= 1'b0;
         rst_prev_ff <= 1'b0;
         pwr_prev_ff <= 1'b0;
      end else begin
         state_ff <= nxt_state;
         clk_fast_ff <= nxt_clk_fast;
         restore_ff <= nxt_restore;
         enabled_ff <= nxt_enabled;
         start_work_ff <= nxt_start_work;
         sel_ff <= nxt_sel;
         rst_prev_ff <= ecu_rst_n;
         pwr_prev_ff <= ecu_pwr;
      end
   end

   // ==========================================================
   // outputs
   assign selected = sel_ff && enabled_ff;
   assign page_512k = cfg_ff.page_512k; // R3
   assign meas_cal_allowed = (cfg_ff.app_mode == psc_pkg::PSC_MODE_MEAS_INIT); // R4
   assign restore_request = restore_ff;
   assign probe_enabled = enabled_ff;
   assign debug_clk_fast = clk_fast_ff; // R8
   assign debug_clk_20mhz = cfg_ff.clk_20mhz; // R8
   assign timer_trigger_en = clk_fast_ff; // R9
   assign debugger_reserved = cfg_ff.arb_static; // R13
   assign start_working_page = start_work_ff;
   assign config_applied = applied_ff;

endmodule // psc_startup

`default_nettype wire

// ### design/psc_consts.svh
`ifndef PSC_CONSTS_SVH
`define PSC_CONSTS_SVH

// register offsets (byte addresses on the plain register port)
`define PSC_REG_CONFIG_A  8'h00
`define PSC_REG_TIMEOUT   8'h04
`define PSC_REG_CONTROL   8'h08
`define PSC_REG_STATUS    8'h0c
`define PSC_REG_LOAD_DATA 8'h10

// config_a field positions
`define PSC_CFG_SEL_LSB   0
`define PSC_CFG_PAGE_BIT  3
`define PSC_CFG_MODE_LSB  4
`define PSC_CFG_PWR_BIT   6
`define PSC_CFG_CLK_BIT   7
`define PSC_CFG_ARB_BIT   8
`define PSC_CFG_START_LSB 9

// reset values: strobe two, 1 MB, measurement initialized, enabled, 40 MHz, dynamic, last page
`define PSC_CFG_RESET     16'h0001
`define PSC_TIMEOUT_RESET 16'h0064
`define PSC_TIMEOUT_INF   16'hffff

// timing
`define PSC_CLK_HZ        25000000
`define PSC_MS_PER_S      1000
`define PSC_MS_CYCLES     (`PSC_CLK_HZ / `PSC_MS_PER_S)

// number of configuration words in the flash image
`define PSC_IMAGE_WORDS   2

`endif

// ### design/psc_pkg.sv
package psc_pkg;

   typedef enum logic [2:0] {
      PSC_SEL_ONE,
      PSC_SEL_TWO,
      PSC_SEL_THREE,
      PSC_SEL_COMB,
      PSC_SEL_ZERO
   } psc_sel_e;

   typedef enum logic [1:0] {
      PSC_MODE_MEAS_INIT,
      PSC_MODE_MEAS_UNINIT,
      PSC_MODE_RAMX_INIT,
      PSC_MODE_RAMX_UNINIT
   } psc_mode_e;

   typedef enum logic [1:0] {
      PSC_START_LAST,
      PSC_START_WORKING,
      PSC_START_REFERENCE
   } psc_start_e;

   typedef struct packed {
      psc_start_e start_page;
      logic arb_static;
      logic clk_20mhz;
      logic power_on_inactive;
      psc_mode_e app_mode;
      logic page_512k;
      psc_sel_e select;
   } psc_cfg_s;

   typedef struct packed {
      logic [7:0] addr;
      logic [15:0] wdata;
      logic wr;
      logic rd;
   } psc_bus_s;

endpackage

// ### design/psc_ms_timer.sv
`timescale 1ns/10ps
`default_nettype none
`include "psc_consts.svh"

// millisecond timer for the post-reset wait
module psc_ms_timer (
   // clock and reset
   input wire logic mclk,
   input wire logic resetn,
   // control
   input wire logic restart,
   input wire logic run,
   // status
   output logic [15:0] ms_count
);

   localparam logic [14:0] MS_LAST = 15'(`PSC_MS_CYCLES - 1);

   logic [14:0] tick_ff;
   logic [14:0] nxt_tick;
   logic [15:0] ms_ff;
   logic [15:0] nxt_ms;

   // ==========================================================
   // divider and counter
   always_comb begin
      nxt_tick = tick_ff;
      nxt_ms = ms_ff;
      if (restart) begin
         nxt_tick = '0; // R15
         nxt_ms = '0;
      end else if (run) begin
         if (tick_ff == MS_LAST) begin
            nxt_tick = '0;
            // saturate so a stalled wait never wraps back into range
            if (ms_ff != 16'hffff) begin
               nxt_ms = ms_ff + 16'h0001; // R15
            end
         end else begin
            nxt_tick = tick_ff + 15'h0001;
         end
      end
   end

   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         tick_ff <= '0;
         ms_ff <= '0;
      end else begin
         tick_ff <= nxt_tick;
         ms_ff <= nxt_ms;
      end
   end

   assign ms_count = ms_ff;

endmodule // psc_ms_timer

`default_nettype wire

// ### design/psc_pin_sync.sv
`timescale 1ns/10ps
`default_nettype none

// three-stage synchroniser; a change counts once stages two and three agree
module psc_pin_sync #(
   parameter int WIDTH = 1
) (
   // clock and reset
   input wire logic mclk,
   input wire logic resetn,
   // pins
   input wire logic [WIDTH-1:0] pin_in,
   output logic [WIDTH-1:0] level_out
);

   logic [WIDTH-1:0] s1_ff;
   logic [WIDTH-1:0] s2_ff;
   logic [WIDTH-1:0] s3_ff;
   logic [WIDTH-1:0] lvl_ff;
   logic [WIDTH-1:0] nxt_lvl;

   // ==========================================================
   // per-bit filter
   genvar i;
   generate
      for (i = 0; i < WIDTH; i++) begin : g_bit
         always_comb begin
            nxt_lvl[i] = (s2_ff[i] == s3_ff[i]) ? s3_ff[i] : lvl_ff[i];
         end
      end
   endgenerate

   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         s1_ff <= '0;
         s2_ff <= '0;
         s3_ff <= '0;
         lvl_ff <= '0;
      end else begin
         s1_ff <= pin_in;
         s2_ff <= s1_ff;
         s3_ff <= s2_ff;
         lvl_ff <= nxt_lvl;
      end
   end

   assign level_out = lvl_ff;

endmodule // psc_pin_sync

`default_nettype wire

// ### tb/psc_monitor.sv
`timescale 1ns/10ps
`default_nettype none
// ====
// port checker for the startup block
module psc_monitor (
   // clock and reset
   input wire logic mclk,
   input wire logic resetn,
   // inputs
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic load_valid,
   input wire logic ecu_reset_n_pin,
   input wire logic ecu_power_pin,
   input wire logic power_fail,
   // outputs
   input wire logic [15:0] reg_rdata,
   input wire logic selected,
   input wire logic page_512k,
   input wire logic meas_cal_allowed,
   input wire logic restore_request,
   input wire logic probe_enabled,
   input wire logic debug_clk_fast,
   input wire logic debug_clk_20mhz,
   input wire logic timer_trigger_en,
   input wire logic debugger_reserved,
   input wire logic config_applied
);
   default clocking mon_cb @(posedge mclk);
   endclocking
   default disable iff (!resetn);
   rdata_idle_a: assert property (!$past(reg_rd) |-> reg_rdata == 16'h0)
      else $error("read data outside its slot");
   // sync, filter and state register put five edges between pin and drop
   trig_drop_a: assert property ($fell(timer_trigger_en) |->
      $past(!ecu_power_pin || !ecu_reset_n_pin, 5))
      else $error("trigger enable dropped while unit running");
   // sync plus filter takes about four edges, eight leaves margin
   fast_drop_a: assert property (!ecu_power_pin [*8] |-> !debug_clk_fast)
      else $error("fast clock kept without power");
   fast_cause_a: assert property ($rose(debug_clk_fast) |-> ecu_power_pin && ecu_reset_n_pin)
      else $error("fast clock while unit not running");
   restore_cause_a: assert property ($rose(restore_request) |-> power_fail)
      else $error("restore without power failure");
   sel_enable_a: assert property (!probe_enabled |-> !selected)
      else $error("selected while inactive");
   cfg_hold_a: assert property ($changed({page_512k, meas_cal_allowed, debugger_reserved,
      debug_clk_20mhz}) |-> $past(reg_wr || load_valid))
      else $error("setting output moved with no write");
   applied_a: assert property ($rose(config_applied) |-> $past(load_valid))
      else $error("image applied without a word");
endmodule // psc_monitor

bind psc_startup psc_monitor u_psc_monitor (.mclk, .resetn, .reg_wr, .reg_rd, .load_valid,
   .ecu_reset_n_pin, .ecu_power_pin, .power_fail, .reg_rdata, .selected, .page_512k,
   .meas_cal_allowed, .restore_request, .probe_enabled, .debug_clk_fast, .debug_clk_20mhz,
   .timer_trigger_en, .debugger_reserved, .config_applied);
`default_nettype wire

// ### tb/psc_ecu_model.sv
`timescale 1ns/10ps
`default_nettype none
// ====
// control unit pins as the probe sees them
module psc_ecu_model (
   // clock
   input wire logic mclk,
   // bench commands
   input wire logic power_cmd,
   input wire logic trig_cmd,
   input wire logic [2:0] strobe_idx,
   // unit pins
   output logic ecu_power_pin,
   output logic ecu_reset_n_pin,
   output logic ecu_trigger_pin,
   output logic [4:0] select_strobes_n
);
   logic [3:0] hold_ff;
   // reset trails power rise, as a supply ramp would
   always_ff @(posedge mclk) begin
      hold_ff <= !power_cmd ? 4'h0 : (hold_ff == 4'hf ? hold_ff : hold_ff + 4'h1);
   end
   assign ecu_power_pin = power_cmd;
   assign ecu_reset_n_pin = (hold_ff == 4'hf);
   assign ecu_trigger_pin = trig_cmd & ecu_reset_n_pin;
   // one strobe at most; index above four leaves all idle
   assign select_strobes_n = ~(5'h01 << strobe_idx);
endmodule // psc_ecu_model
`default_nettype wire

// ### tb/tb.sv
`timescale 1ns/10ps
`default_nettype none
// ====
// bench top
module tb;
   typedef struct packed {
      logic [15:0] cfg;
      logic [3:0] exp;
   } psc_row_s;
   logic mclk = 1'b0, resetn = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, load_valid = 1'b0;
   logic power_fail = 1'b0, last_page_working = 1'b1, power_cmd = 1'b0, trig_cmd = 1'b0;
   logic [7:0] reg_addr = 8'h00;
   logic [15:0] reg_wdata = 16'h0000, load_word = 16'h0000, reg_rdata;
   logic [2:0] strobe_idx = 3'h7;
   logic [4:0] select_strobes_n;
   logic ecu_power_pin, ecu_reset_n_pin, ecu_trigger_pin, selected, page_512k;
   logic meas_cal_allowed, restore_request, probe_enabled, debug_clk_fast, debug_clk_20mhz;
   logic timer_trigger_en, debugger_reserved, start_working_page, config_applied;
   int miscompares = 0;
   int check_count = 0;
   // outputs {page_512k, meas_cal_allowed, debugger_reserved, debug_clk_20mhz}
   psc_row_s rows [7] = '{'{16'h0009, 4'b1100}, '{16'h0011, 4'b0000}, '{16'h0021, 4'b0000},
      '{16'h0031, 4'b0000}, '{16'h0081, 4'b0101}, '{16'h0101, 4'b0110}, '{16'h0001, 4'b0100}};
   logic [15:0] starts [3] = '{16'h0001, 16'h0241, 16'h0401};
   logic [15:0] waits [2] = '{16'hffff, 16'h0003};
   always #20 mclk = ~mclk;
   psc_startup u_psc_startup (.mclk, .resetn, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
      .reg_rdata, .load_valid, .load_word, .ecu_reset_n_pin, .ecu_power_pin, .ecu_trigger_pin,
      .power_fail, .select_strobes_n, .last_page_working, .selected, .page_512k,
      .meas_cal_allowed, .restore_request, .probe_enabled, .debug_clk_fast, .debug_clk_20mhz,
      .timer_trigger_en, .debugger_reserved, .start_working_page, .config_applied);
   psc_ecu_model u_psc_ecu_model (.mclk, .power_cmd, .trig_cmd, .strobe_idx, .ecu_power_pin,
      .ecu_reset_n_pin, .ecu_trigger_pin, .select_strobes_n);
   // ====
   // tasks
   task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
      check_count++;
      if (g !== e) begin
         miscompares++;
         $display("BAD %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic wt(input int n);
      repeat (n) @(posedge mclk);
      #1;
   endtask
   task automatic wr(input logic [7:0] a, input logic [15:0] d);
      @(posedge mclk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge mclk);
      reg_wr <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, input logic [15:0] e);
      @(posedge mclk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge mclk);
      reg_rd <= 1'b0;
      #1;
      chk("rdata", e, reg_rdata);
   endtask
   task automatic ld(input logic [15:0] w);
      @(posedge mclk);
      load_valid <= 1'b1;
      load_word <= w;
      @(posedge mclk);
      load_valid <= 1'b0;
   endtask
   task automatic pcyc();
      power_cmd <= 1'b0;
      wt(20);
      chk("fast", 0, debug_clk_fast);
      power_cmd <= 1'b1;
      wt(40);
   endtask
   task automatic wfast(input int n);
      for (int i = 0; i < n && debug_clk_fast !== 1'b1; i++) @(posedge mclk);
      #1;
      chk("fast", 1, debug_clk_fast);
   endtask
   task automatic rstchk();
      chk("outs", 4'b0100, {page_512k, meas_cal_allowed, debugger_reserved, debug_clk_20mhz});
      chk("fast", 0, debug_clk_fast);
      chk("applied", 0, config_applied);
      rd(8'h00, 16'h0001);
      rd(8'h04, 16'h0064);
      rd(8'h10, 16'h0000);
   endtask
   task automatic test_done();
      $display("checks %0d mismatches %0d", check_count, miscompares);
      if (miscompares == 0 && check_count > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   // ====
   // watchdog: the longest wait is two milliseconds, about 50000 cycles
   initial begin
      repeat (70000) @(posedge mclk);
      miscompares++;
      test_done();
   end
   // ====
   // main sequence
   initial begin
      repeat (20) @(posedge mclk);
      resetn <= 1'b1;
      wt(1);
      rstchk();
      $display("reset test done");
      foreach (rows[i]) begin
         wr(8'h00, rows[i].cfg);
         wt(2);
         chk("outs", rows[i].exp, {page_512k, meas_cal_allowed, debugger_reserved, debug_clk_20mhz});
         rd(8'h00, rows[i].cfg);
      end
      $display("table test done");
      wr(8'h04, 16'h0000);
      power_cmd <= 1'b1;
      wt(40);
      chk("enabled", 1, probe_enabled);
      chk("trig en", 1, timer_trigger_en);
      for (int s = 0; s < 5; s++) begin
         wr(8'h00, 16'(s));
         strobe_idx <= 3'((s + 1) % 5);
         wt(8);
         chk("sel", 1, selected);
         strobe_idx <= 3'((s + 2) % 5);
         wt(8);
         chk("sel", 0, selected);
      end
      strobe_idx <= 3'h7;
      $display("strobe test done");
      foreach (starts[i]) begin
         wr(8'h00, starts[i]);
         pcyc();
         chk("start", i != 2, start_working_page);
         chk("enabled", i != 1, probe_enabled);
      end
      $display("start test done");
      foreach (waits[i]) begin
         wr(8'h04, waits[i]);
         pcyc();
         wt(300);
         chk("fast", 0, debug_clk_fast);
         trig_cmd <= 1'b1;
         wfast(20);
         trig_cmd <= 1'b0;
      end
      wr(8'h04, 16'h0002);
      pcyc();
      wt(49900);
      chk("fast", 0, debug_clk_fast);
      wfast(300);
      $display("timeout test done");
      power_fail <= 1'b1;
      wt(10);
      chk("restore", 1, restore_request);
      power_fail <= 1'b0;
      ld(16'h0011);
      ld(16'h0000);
      wt(10);
      chk("applied", 1, config_applied);
      chk("meas", 0, meas_cal_allowed);
      chk("restore", 0, restore_request);
      power_fail <= 1'b1;
      wt(10);
      chk("restore", 0, restore_request);
      power_fail <= 1'b0;
      rd(8'h04, 16'h0000);
      rd(8'h08, 16'h0000);
      wr(8'h08, 16'h0001);
      rd(8'h10, 16'h0000);
      rd(8'h14, 16'h0000);
      $display("restore test done");
      resetn <= 1'b0;
      wt(3);
      resetn <= 1'b1;
      wt(1);
      rstchk();
      $display("second reset test done");
      test_done();
   end
endmodule // tb
`default_nettype wire
